//--- hw/hic_irq_ctrl.sv
// Host interrupt request output control: pending flags, mask, hold-off
// timer, pin enable, polarity and driver type, plus identity register.
// Assumes host accesses synchronous to i_ref_clk, one cycle per access.
//
// Overview of operation
// - Event inputs set pending flags, one bit per source
// - Host clears a flag by writing one to it
// - Mask picks which flags reach the combined line
// - Combined line reads back in the config register
// - Pin logic adds enable, hold-off, polarity, driver type
//
// Hold-off behaviour
// - Interval counts in steps of the 10 us tick
// - Starts when the logical request drops
// - Restart bit starts a fresh interval at any time
// - Zero interval cancels hold-off at once
// - Held interrupts show again when the interval ends
// - Power event source is never held off
//
// Timing summary
// - Pin outputs registered, one cycle behind logic
// - Read data registered, answer pulse next cycle
// - Writes take effect on the edge they are sampled
//
// Reset summary
// - System reset clears every register and the pin
// - Software reset spares the driver-type bit
// - Pin flops follow logic after software reset
//
// Limitations
// - Full 32-bit accesses only, no byte lanes
// - Tick length fixed by the package clock period
// - Shortened interval ends at the next tick
// - Restart with zero interval starts no hold-off at all
// - Reserved bits are dropped on write, read zero
//
// Trade-offs
// - Live interval compare, so no shadow copy needed
// - Prescaler idles outside intervals to save toggles
// - Open-drain never drives high, safe on shared wire
//
// Integration hints
// - Tie i_soft_rst low if no software reset exists
// - Event inputs may be level or pulse
// - Pull-up required on the pin when open-drain
// - Pin output enable high while driving

// Notes on behaviour
// - Interval byte 31:24, steps of 10 us
// - Zero interval disables hold-off, releases pending
// - New non-zero interval governs later interrupts
// - Power event source bypasses hold-off
// - Bit 14 restarts interval, self clears
// - Bit 13 shows hold-off in progress
// - Bit 12 shows combined internal line
// - Bit 8 low keeps pin deasserted
// - Bit 4 picks pin polarity
// - Bit 0 picks open-drain or push-pull
// - Open-drain forces active low, ignores polarity
// - Identity register: design id, revision
// - Config, pending, mask at 54h, 58h, 5Ch
// - Config fields all zero after reset
// - Driver bit survives software reset only
// - Writing one clears pending flag
module hic_irq_ctrl #(
  parameter logic [15:0] DESIGN_ID = hic_pkg::DESIGN_ID_DFLT,
  parameter logic [15:0] REVISION  = hic_pkg::REVISION_DFLT
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_soft_rst,
  input  wire hic_pkg::hic_host_req_t i_host_req,
  input  wire logic [31:0]            i_src_event,
  output logic [31:0]                 o_host_rdata,
  output logic                        o_host_rvalid,
  output logic                        o_irq_out,
  output logic                        o_irq_oe
);

  // Every register other than the driver-type bit and the pin flops sees both resets
  logic        any_rst;

  // Decoded host strokes
  logic        wr_cfg;
  logic        wr_pending;
  logic        wr_mask;
  logic        rd_stb;

  // Configuration state
  logic [7:0]  interval_ff;
  logic        pin_en_ff;
  logic        polarity_ff;
  logic        driver_pp_ff;

  // Pending flags and mask
  logic [31:0] pending_ff;
  logic [31:0] nxt_pending;
  logic [31:0] mask_ff;

  // Combined lines
  logic [31:0] enabled_flags;
  logic        master_line;
  logic        power_line;

  // Hold-off timer state
  logic                         holdoff_active_ff;
  logic [hic_pkg::TICK_CNT_W-1:0] prescale_ff;
  logic [7:0]                   tick_cnt_ff;
  logic                         tick;
  logic                         restart_req;
  logic                         interval_zero;
  logic                         expire;

  // Pin assertion state
  logic        assert_now;
  logic        asserted_ff;
  logic        deassert_edge;
  hic_pkg::hic_pin_t nxt_pin;

  // Readback
  logic [31:0] cfg_view;
  logic [31:0] nxt_rdata;

  assign any_rst = i_rst | i_soft_rst;

  // Address decode; other offsets are not ours and are ignored on write
  assign wr_cfg     = i_host_req.sel & i_host_req.wr &
                      (i_host_req.addr == hic_pkg::PIN_CFG_OFS);
  assign wr_pending = i_host_req.sel & i_host_req.wr &
                      (i_host_req.addr == hic_pkg::PENDING_OFS);
  assign wr_mask    = i_host_req.sel & i_host_req.wr &
                      (i_host_req.addr == hic_pkg::MASK_OFS);
  assign rd_stb     = i_host_req.sel & i_host_req.rd;

  // Interval, pin enable and polarity follow both resets
  always_ff @(posedge i_ref_clk) begin
    if (any_rst) begin
      interval_ff <= hic_pkg::PIN_CFG_RST[hic_pkg::INTERVAL_MSB:hic_pkg::INTERVAL_LSB];
      pin_en_ff   <= hic_pkg::PIN_CFG_RST[hic_pkg::PIN_EN_BIT];
      polarity_ff <= hic_pkg::PIN_CFG_RST[hic_pkg::POLARITY_BIT];
    end else if (wr_cfg) begin
      // Reserved bits are dropped; host keeps them zero
      interval_ff <= i_host_req.wdata[hic_pkg::INTERVAL_MSB:hic_pkg::INTERVAL_LSB];
      pin_en_ff   <= i_host_req.wdata[hic_pkg::PIN_EN_BIT];
      polarity_ff <= i_host_req.wdata[hic_pkg::POLARITY_BIT];
    end
  end

  // Driver type ignores the software reset so a shared wire stays safe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      driver_pp_ff <= hic_pkg::PIN_CFG_RST[hic_pkg::DRIVER_BIT];
    end else if (wr_cfg) begin
      driver_pp_ff <= i_host_req.wdata[hic_pkg::DRIVER_BIT];
    end
  end

  // Mask register, plain read/write
  always_ff @(posedge i_ref_clk) begin
    if (any_rst) begin
      mask_ff <= hic_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_ff <= i_host_req.wdata;
    end
  end

  // Pending flags: a new event in the clear cycle wins over the clear
  always_comb begin
    nxt_pending = pending_ff;
    if (wr_pending) begin
      nxt_pending = nxt_pending & ~i_host_req.wdata;
    end
    nxt_pending = nxt_pending | i_src_event;
  end

  always_ff @(posedge i_ref_clk) begin
    if (any_rst) begin
      pending_ff <= hic_pkg::PENDING_RST;
    end else begin
      pending_ff <= nxt_pending;
    end
  end

  // Combined internal line, independent of pin enable and hold-off
  assign enabled_flags = pending_ff & mask_ff;
  assign master_line   = |enabled_flags;
  assign power_line    = enabled_flags[hic_pkg::POWER_EVENT_BIT];

  // Hold-off control terms
  assign restart_req   = wr_cfg & i_host_req.wdata[hic_pkg::RESTART_BIT];
  assign interval_zero = (interval_ff == 8'h00);
  assign tick          = (prescale_ff == hic_pkg::TICK_LAST);
  // Compare against the live setting so a new value takes effect at once
  assign expire        = tick & ((tick_cnt_ff + 8'h01) >= interval_ff);

  // Pin goes quiet while hold-off runs, except for the power event
  assign assert_now    = pin_en_ff &
                         ((master_line & ~holdoff_active_ff) | power_line);
  assign deassert_edge = asserted_ff & ~assert_now;

  // Hold-off interval state
  // Priority order matters here:
  // - A zero write wins over everything else
  // - Restart beats a running or idle interval
  // - A stored zero keeps the timer parked
  // - A pin deassertion opens a new interval
  // - Expiry closes the interval last
  // Hazard: reordering lets a stale restart reopen hold-off
  always_ff @(posedge i_ref_clk) begin
    if (any_rst) begin
      holdoff_active_ff <= 1'b0;
    end else if (wr_cfg &&
                 i_host_req.wdata[hic_pkg::INTERVAL_MSB:hic_pkg::INTERVAL_LSB] == 8'h00) begin
      // Zero written: drop hold-off, held interrupts pass next cycle
      holdoff_active_ff <= 1'b0;
    end else if (restart_req) begin
      holdoff_active_ff <= 1'b1;
    end else if (interval_zero) begin
      holdoff_active_ff <= 1'b0;
    end else if (deassert_edge) begin
      holdoff_active_ff <= 1'b1;
    end else if (holdoff_active_ff && expire) begin
      holdoff_active_ff <= 1'b0;
    end
  end

  // Prescaler makes the 10 us tick; it only runs inside an interval
  // Cleared on every start so each interval is whole ticks
  // Limitation: first tick lands a full tick after start
  always_ff @(posedge i_ref_clk) begin
    if (any_rst) begin
      prescale_ff <= '0;
    end else if (restart_req || deassert_edge || interval_zero || !holdoff_active_ff) begin
      prescale_ff <= '0;
    end else if (tick) begin
      prescale_ff <= '0;
    end else begin
      prescale_ff <= prescale_ff + hic_pkg::TICK_CNT_W'(1);
    end
  end

  // Tick count inside the interval
  // Eight bits cover the largest interval value
  // Count never wraps: expiry stops the interval first
  always_ff @(posedge i_ref_clk) begin
    if (any_rst) begin
      tick_cnt_ff <= 8'h00;
    end else if (restart_req || deassert_edge || interval_zero || !holdoff_active_ff) begin
      tick_cnt_ff <= 8'h00;
    end else if (tick) begin
      tick_cnt_ff <= tick_cnt_ff + 8'h01;
    end
  end

  // Remember the logical pin state to catch the deassertion
  always_ff @(posedge i_ref_clk) begin
    if (any_rst) begin
      asserted_ff <= 1'b0;
    end else begin
      asserted_ff <= assert_now;
    end
  end

  // Pin drive: open-drain pulls low only, push-pull obeys polarity
  // Open-drain releases the wire when idle; pull-up gives high
  // Push-pull always drives, idle level is inverse of active
  always_comb begin
    nxt_pin = '0;
    if (!driver_pp_ff) begin
      nxt_pin.out = 1'b0;
      nxt_pin.oe  = assert_now;
    end else begin
      nxt_pin.oe  = 1'b1;
      nxt_pin.out = polarity_ff ? assert_now : ~assert_now;
    end
  end

  // Registered pin outputs; a push-pull pin idles high-level-low safely
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_irq_out <= 1'b0;
      o_irq_oe  <= 1'b0;
    end else begin
      o_irq_out <= nxt_pin.out;
      o_irq_oe  <= nxt_pin.oe;
    end
  end

  // Config readback; restart bit always reads zero, reserved bits zero
  always_comb begin
    cfg_view = 32'h00000000;
    cfg_view[hic_pkg::INTERVAL_MSB:hic_pkg::INTERVAL_LSB] = interval_ff;
    cfg_view[hic_pkg::ACTIVE_BIT]   = holdoff_active_ff;
    cfg_view[hic_pkg::MASTER_BIT]   = master_line;
    cfg_view[hic_pkg::PIN_EN_BIT]   = pin_en_ff;
    cfg_view[hic_pkg::POLARITY_BIT] = polarity_ff;
    cfg_view[hic_pkg::DRIVER_BIT]   = driver_pp_ff;
  end

  // Read mux; unmapped offsets answer zero
  // Identity word is fixed by parameters, writes ignored
  // Pending flags read raw, before the mask
  always_comb begin
    case (i_host_req.addr)
      hic_pkg::CHIP_IDENTITY_REVISION_OFS:  nxt_rdata = {DESIGN_ID, REVISION};
      hic_pkg::PIN_CFG_OFS: nxt_rdata = cfg_view;
      hic_pkg::PENDING_OFS: nxt_rdata = pending_ff;
      hic_pkg::MASK_OFS:    nxt_rdata = mask_ff;
      default:              nxt_rdata = 32'h00000000;
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge i_ref_clk) begin
    if (any_rst) begin
      o_host_rdata <= hic_pkg::RDATA_RST;
    end else if (rd_stb) begin
      o_host_rdata <= nxt_rdata;
    end
  end

  // One-cycle read answer strobe
  always_ff @(posedge i_ref_clk) begin
    if (any_rst) begin
      o_host_rvalid <= 1'b0;
    end else begin
      o_host_rvalid <= rd_stb;
    end
  end

endmodule : hic_irq_ctrl

//--- hw/hic_pkg.sv
// Package for the host interrupt output control block.
// Assumes a 40 MHz system clock and 32-bit host accesses on word offsets.
package hic_pkg;

  // Register byte offsets on the host bus
  localparam logic [7:0] CHIP_IDENTITY_REVISION_OFS   = 8'h50;
  localparam logic [7:0] PIN_CFG_OFS  = 8'h54;
  localparam logic [7:0] PENDING_OFS  = 8'h58;
  localparam logic [7:0] MASK_OFS     = 8'h5C;

  // Field positions in interrupt_pin_config
  localparam int INTERVAL_LSB  = 24;
  localparam int INTERVAL_MSB  = 31;
  localparam int RESTART_BIT   = 14;
  localparam int ACTIVE_BIT    = 13;
  localparam int MASTER_BIT    = 12;
  localparam int PIN_EN_BIT    = 8;
  localparam int POLARITY_BIT  = 4;
  localparam int DRIVER_BIT    = 0;

  // Power event source position in the pending flags
  localparam int POWER_EVENT_BIT = 17;

  // Reset values
  localparam logic [31:0] PIN_CFG_RST = 32'h00000000;
  localparam logic [31:0] PENDING_RST = 32'h00000000;
  localparam logic [31:0] MASK_RST    = 32'h00000000;
  localparam logic [31:0] RDATA_RST   = 32'h00000000;

  // Identity defaults, values arbitrary
  localparam logic [15:0] DESIGN_ID_DFLT = 16'hA5C3;
  localparam logic [15:0] REVISION_DFLT  = 16'h0001;

  // Hold-off tick timing
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int TICK_PERIOD_US = 10;
  localparam int TICK_CYCLES    = (TICK_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  localparam int TICK_CNT_W     = $clog2(TICK_CYCLES);
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

  // One host bus access, sampled on the clock edge
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } hic_host_req_t;

  // Pin drive pair for the request output
  typedef struct packed {
    logic out;
    logic oe;
  } hic_pin_t;

endpackage : hic_pkg

//--- verification/hic_irq_ctrl_assertions.sv
// Checker for the host interrupt output block.
// Bound to hic_irq_ctrl; sees only its ports, keeps a shadow of pin controls.
module hic_irq_ctrl_assertions #(
  parameter logic [15:0] DESIGN_ID = hic_pkg::DESIGN_ID_DFLT,
  parameter logic [15:0] REVISION  = hic_pkg::REVISION_DFLT
) (
  input wire logic                   i_ref_clk,
  input wire logic                   i_rst,
  input wire logic                   i_soft_rst,
  input wire hic_pkg::hic_host_req_t i_host_req,
  input wire logic [31:0]            i_src_event,
  input wire logic [31:0]            o_host_rdata,
  input wire logic                   o_host_rvalid,
  input wire logic                   o_irq_out,
  input wire logic                   o_irq_oe
);
  logic en_ff, pol_ff, drv_ff, rd, wcfg, cfg;
  // Plain reads only; a read beside a write or soft reset is left open
  assign rd = i_host_req.sel && i_host_req.rd && !i_host_req.wr && !i_soft_rst;
  assign wcfg = i_host_req.sel && i_host_req.wr && i_host_req.addr == hic_pkg::PIN_CFG_OFS;
  assign cfg = rd && i_host_req.addr == hic_pkg::PIN_CFG_OFS;
  // Shadow of enable and polarity, cleared by either reset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_soft_rst) begin
      en_ff  <= 1'b0;
      pol_ff <= 1'b0;
    end else if (wcfg) begin
      en_ff  <= i_host_req.wdata[8];
      pol_ff <= i_host_req.wdata[4];
    end
  end
  // Driver bit survives soft reset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) drv_ff <= 1'b0;
    else if (wcfg) drv_ff <= i_host_req.wdata[0];
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  AST_RVALID: assert property (o_host_rvalid == $past(i_host_req.sel && i_host_req.rd))
    else $error("read answer pulse wrong");
  AST_ID: assert property (rd && i_host_req.addr == hic_pkg::CHIP_IDENTITY_REVISION_OFS
    |=> o_host_rdata == {DESIGN_ID, REVISION}) else $error("identity read wrong");
  AST_UNMAP: assert property (rd && !(i_host_req.addr inside {8'h50, 8'h54, 8'h58, 8'h5C})
    |=> o_host_rdata == 32'h0) else $error("unmapped read not zero");
  AST_RESERVED: assert property (cfg |=> (o_host_rdata & 32'h00FFCEEE) == 32'h0)
    else $error("restart or reserved bits read nonzero");
  AST_CFG_RB: assert property (cfg |=> {o_host_rdata[8], o_host_rdata[4], o_host_rdata[0]}
    == {en_ff, pol_ff, drv_ff}) else $error("config readback wrong");
  AST_PIN_OFF: assert property (!en_ff && $stable({en_ff, pol_ff, drv_ff})
    |-> (drv_ff ? (o_irq_oe && o_irq_out == !pol_ff) : !o_irq_oe)) else $error("pin not off");
  AST_OD_LOW: assert property (!drv_ff && $stable(drv_ff) |-> !o_irq_out)
    else $error("open drain drives high");
  AST_PP_OE: assert property (drv_ff && $stable(drv_ff) |-> o_irq_oe)
    else $error("push pull not driving");
  cover property (o_irq_oe && o_irq_out);
  cover property (cfg ##1 o_host_rdata[13]);
  cover property (i_soft_rst && drv_ff);
endmodule // hic_irq_ctrl_assertions

//--- verification/hic_pin_model.sv
// Request pin wire as the host side sees it.
// Assumes a pull-up on the shared line, so a released pin reads high.
module hic_pin_model (
  input  wire logic i_out,
  input  wire logic i_oe,
  output logic      o_level
);
  // Pull-up wins when nobody drives
  assign o_level = i_oe ? i_out : 1'b1;
endmodule // hic_pin_model

//--- verification/testbench.sv
// Self-checking bench for the host interrupt output block.
// Drives register port and events; pin level seen through hic_pin_model.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 1'b0, rst = 1'b1, srst = 1'b0, rv, oe, po, lvl;
  logic [31:0]            ev = '0, rdat, v;
  hic_pkg::hic_host_req_t req = '0;
  int                     bad_count = 0, n_tests = 0, k;
  always #12.5 clk = ~clk;
  hic_irq_ctrl DUT (.i_ref_clk(clk), .i_rst(rst), .i_soft_rst(srst), .i_host_req(req),
    .i_src_event(ev), .o_host_rdata(rdat), .o_host_rvalid(rv), .o_irq_out(po), .o_irq_oe(oe));
  hic_pin_model u_pin (.i_out(po), .i_oe(oe), .o_level(lvl));
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask
  // Bus tasks start and end on a rising edge; one idle edge keeps drives apart
  task automatic wr(logic [7:0] a, logic [31:0] d);
    req <= '{1'b1, 1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rchk(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    req <= '{1'b1, 1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    req <= '0;
    #1;
    chk("rvalid", 32'h1, {31'h0, rv});
    chk("reg", e, rdat & m);
    @(posedge clk);
  endtask
  task automatic fire(logic [31:0] b);
    ev <= b;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask
  // Pin outputs lag; three edges leave margin past the registered stage
  task automatic pin(logic e);
    repeat (3) @(posedge clk);
    #1;
    chk("pin", {31'h0, e}, {31'h0, lvl});
    @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(8'h50, 32'h0);
    rchk(8'h50, '1, {hic_pkg::DESIGN_ID_DFLT, hic_pkg::REVISION_DFLT});
    rchk(8'h54, '1, 32'h0);
    rchk(8'h58, '1, 32'h0);
    rchk(8'h5C, '1, 32'h0);
    rchk(8'h60, '1, 32'h0);
    $display("test reset done");
    wr(8'h5C, 32'h00020008);
    fire(32'h8);
    rchk(8'h54, 32'h1000, 32'h1000);
    pin(1'b1);
    wr(8'h54, 32'h111);
    pin(1'b1);
    wr(8'h54, 32'h101);
    pin(1'b0);
    wr(8'h54, 32'h110);
    pin(1'b0);
    wr(8'h58, 32'h8);
    rchk(8'h58, '1, 32'h0);
    pin(1'b1);
    fire(32'h20);
    rchk(8'h54, 32'h1000, 32'h0);
    $display("test pin done");
    wr(8'h54, 32'h02000101);
    fire(32'h8);
    pin(1'b0);
    wr(8'h58, 32'h8);
    fire(32'h8);
    pin(1'b1);
    rchk(8'h54, 32'h2000, 32'h2000);
    repeat (700) @(posedge clk);
    pin(1'b1);
    for (k = 0; k < 200 && lvl !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 200) begin
      bad_count++;
      final_report();
    end
    pin(1'b0);
    wr(8'h54, 32'h02004101);
    pin(1'b1);
    rchk(8'h54, 32'h6000, 32'h2000);
    wr(8'h54, 32'h101);
    pin(1'b0);
    rchk(8'h54, 32'h2000, 32'h0);
    wr(8'h54, 32'h02004101);
    pin(1'b1);
    fire(32'h20000);
    pin(1'b0);
    $display("test holdoff done");
    wr(8'h54, 32'h111);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rchk(8'h54, 32'hFF001111, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(8'h54, '1, 32'h0);
    $display("test reset kinds done");
    final_report();
  end
endmodule // testbench
bind hic_irq_ctrl hic_irq_ctrl_assertions #(.DESIGN_ID(DESIGN_ID), .REVISION(REVISION)) u_chk (
  .i_ref_clk, .i_rst, .i_soft_rst, .i_host_req, .i_src_event, .o_host_rdata, .o_host_rvalid,
  .o_irq_out, .o_irq_oe);
